// ==== shared/spi_port_pkg.sv ====
/*
  Package for the serial peripheral port: register indices, field positions,
  reset values and state enumeration.
  Assumes a 32-bit Avalon-MM slave with word addresses (index = byte offset / 4).
*/
package spi_port_pkg;
  // Register indices (word address)
  localparam logic [2:0] REG_CTRL_ONE = 3'h0;
  localparam logic [2:0] REG_CTRL_TWO = 3'h1;
  localparam logic [2:0] REG_BAUD = 3'h2;
  localparam logic [2:0] REG_STATUS = 3'h3;
  localparam logic [2:0] REG_DATA_HIGH = 3'h4;
  localparam logic [2:0] REG_DATA_LOW = 3'h5;

  // Control one fields
  localparam int C1_IRQ_EN = 7;
  localparam int C1_SYS_EN = 6;
  localparam int C1_TXE_IRQ_EN = 5;
  localparam int C1_MASTER = 4;
  localparam int C1_CLOCK_POLARITY = 3;
  localparam int C1_CLOCK_PHASE = 2;
  localparam int C1_SEL_OE = 1;
  localparam int C1_LSB_FIRST = 0;
  // Control two fields
  localparam int C2_WIDTH = 6;
  localparam int C2_MODE_FAULT_FLAG_EN = 4;
  localparam logic [7:0] C2_MASK = 8'h50;
  // Baud fields
  localparam logic [7:0] BAUD_MASK = 8'h77;
  localparam int BAUD_PRE_LSB = 4;
  // Status fields
  localparam int S_DONE = 7;
  localparam int S_TXE = 5;
  localparam int S_MODE_FAULT_FLAG = 4;

  localparam logic [7:0] CTRL_ONE_RST = 8'h04;
  localparam logic [7:0] CTRL_TWO_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;

  typedef enum logic [1:0] {IDLE, LEAD, SHIFT, TRAIL} xfer_state_t;
endpackage

// ==== hdl/spi_port.sv ====
/*
  Serial peripheral port, master or slave, with byte-wide control, baud, status
  and split 16-bit data registers on an Avalon-MM slave.
  Assumes pin inputs are synchronous to ref_clk and the slave clock is slow
  enough (at most ref_clk/4) to be edge-detected.
*/
// Notes on behaviour
// - System enable hands pins to the port; clearing idles it and clears flags.
// - Irq enable raises irq while transfer-done or mode-fault flag set.
// - Tx-empty irq enable raises irq while system enable and tx-empty flag set.
// - Master select chooses mode; any mode change forces idle.
// - Clock polarity sets idle level of serial clock.
// - Clock phase samples on odd edges at 0, even edges at 1.
// - Select pin driven as output only in master with mode-fault enable and select enable.
// - Lsb-first bit picks shift order.
// - Data register keeps MSB in top position regardless of order.
// - In master, changing polarity, phase, select enable or order aborts transfer.
// - Reserved bits read zero and ignore writes.
// - Master drives MOSI, slave receives on MOSI.
// - Slave drives MISO, master receives on MISO.
// - Master may drive select; slave takes select as input from master.
// - Master makes serial clock; slave shifts on the external clock.
// - Width bit selects 8-bit low byte or 16-bit both bytes.
// - Master with mode-fault enable and select enable clear: select is fault input.
// - Serial clock = bus clock / ((pre+1) * 2^(sel+1)).
`timescale 1ns/1ps
module spi_port
  import spi_port_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [2:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irqReq,
  output logic sclkOut,
  output logic sclkOe,
  input wire logic sclkIn,
  output logic mosiOut,
  output logic mosiOe,
  input wire logic mosiIn,
  output logic misoOut,
  output logic misoOe,
  input wire logic misoIn,
  output logic selNOut,
  output logic selNOe,
  input wire logic selNIn
);

  // ----------------------------------------------------------------
  // Registers and bus slave
  // ----------------------------------------------------------------
  logic [7:0] ctrlOne_q, ctrlTwo_q, baud_q;
  logic [15:0] txBuf_q, rxBuf_q, shift_q;
  logic txFull_q, done_q, mode_fault_flag_q;
  logic wrHit, rdHit, abort, txLoad, modfHit, finish;
  xfer_state_t state_q;

  function automatic logic [15:0] bitRev(input logic [15:0] v, input logic wide);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[15 - i];
    end
    bitRev = wide ? r : {r[15:8], 8'h00};
  endfunction

  assign wrHit = write && !waitrequest;
  assign rdHit = read && waitrequest;

  // One wait state on every access, answered next cycle
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !((read || write) && waitrequest);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ctrlOne_q <= CTRL_ONE_RST;
      ctrlTwo_q <= CTRL_TWO_RST;
      baud_q <= BAUD_RST;
    end else if (wrHit) begin
      if (address == REG_CTRL_ONE) begin
        ctrlOne_q <= writedata[7:0];
      end else if (address == REG_CTRL_TWO) begin
        ctrlTwo_q <= writedata[7:0] & C2_MASK;
      end else if (address == REG_BAUD) begin
        baud_q <= writedata[7:0] & BAUD_MASK;
      end
    end
  end

  logic enable, master, clock_polarity, clock_phase, lsbFirst, wide, mode_fault_enable, selOe;
  assign enable = ctrlOne_q[C1_SYS_EN];
  assign master = ctrlOne_q[C1_MASTER];
  assign clock_polarity = ctrlOne_q[C1_CLOCK_POLARITY];
  assign clock_phase = ctrlOne_q[C1_CLOCK_PHASE];
  assign lsbFirst = ctrlOne_q[C1_LSB_FIRST];
  assign wide = ctrlTwo_q[C2_WIDTH];
  assign mode_fault_enable = ctrlTwo_q[C2_MODE_FAULT_FLAG_EN];
  assign selOe = ctrlOne_q[C1_SEL_OE];

  logic [7:0] status;
  assign status = {done_q, 1'b0, !txFull_q, mode_fault_flag_q, 4'h0};

  // read data MSB-top; high byte reads zero in 8-bit width
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      readdata <= 32'h0;
    end else if (rdHit) begin
      if (address == REG_CTRL_ONE) begin
        readdata <= {24'h0, ctrlOne_q};
      end else if (address == REG_CTRL_TWO) begin
        readdata <= {24'h0, ctrlTwo_q};
      end else if (address == REG_BAUD) begin
        readdata <= {24'h0, baud_q};
      end else if (address == REG_STATUS) begin
        readdata <= {24'h0, status};
      end else if (address == REG_DATA_HIGH) begin
        readdata <= {24'h0, wide ? rxBuf_q[15:8] : 8'h00};
      end else if (address == REG_DATA_LOW) begin
        readdata <= {24'h0, rxBuf_q[7:0]};
      end else begin
        readdata <= 32'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Abort detection
  // ----------------------------------------------------------------
  logic [7:0] lastC1_q, lastC2_q, lastBaud_q;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      lastC1_q <= CTRL_ONE_RST;
      lastC2_q <= CTRL_TWO_RST;
      lastBaud_q <= BAUD_RST;
    end else begin
      lastC1_q <= ctrlOne_q;
      lastC2_q <= ctrlTwo_q;
      lastBaud_q <= baud_q;
    end
  end
  // idle on disable, mode change or master-mode format change
  assign abort = !enable
    || (lastC1_q[C1_MASTER] != master)
    || (master && ((lastC1_q[3:0] != ctrlOne_q[3:0]) || (lastC2_q != ctrlTwo_q)
                   || (lastBaud_q != baud_q)));

  // ----------------------------------------------------------------
  // Baud divider
  // ----------------------------------------------------------------
  // half period = (pre+1) * 2^sel bus clocks
  logic [10:0] divCnt_q, halfDiv;
  logic tick;
  assign halfDiv = 11'((baud_q[6:4] + 4'h1) << baud_q[2:0]);
  assign tick = (divCnt_q == halfDiv - 11'h1);
  always_ff @(posedge ref_clk) begin
    if (!nrst || state_q == IDLE || abort) begin
      divCnt_q <= 11'h0;
    end else if (tick) begin
      divCnt_q <= 11'h0;
    end else begin
      divCnt_q <= divCnt_q + 11'h1;
    end
  end

  // ----------------------------------------------------------------
  // Slave edge detection
  // ----------------------------------------------------------------
  logic sclkPrev_q, selPrev_q;
  logic slvSel, slvEdge;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sclkPrev_q <= 1'b0;
      selPrev_q <= 1'b1;
    end else begin
      sclkPrev_q <= sclkIn;
      selPrev_q <= selNIn;
    end
  end
  // slave runs from external select and clock
  assign slvSel = !master && !selNIn;
  assign slvEdge = slvSel && (sclkIn != sclkPrev_q);

  // ----------------------------------------------------------------
  // Shift engine
  // ----------------------------------------------------------------
  logic [4:0] edgeCnt_q, lastEdge;
  logic stepEdge, sampleEdge, rxBit;
  assign lastEdge = wide ? 5'h1F : 5'h0F;
  // odd edges (count 0,2,..) sample when phase 0
  assign sampleEdge = (edgeCnt_q[0] == clock_phase);
  assign stepEdge = master ? (state_q == SHIFT && tick) : slvEdge;
  assign rxBit = master ? misoIn : mosiIn;
  assign txLoad = enable && txFull_q && (state_q == IDLE) && !abort
    && (master || slvSel);

  logic sclkQ, takeBit, sampleDly_q, lastDly_q;
  logic [15:0] rxAsm_q;

  always_ff @(posedge ref_clk) begin
    if (!nrst || abort) begin
      state_q <= IDLE;
      edgeCnt_q <= 5'h0;
      shift_q <= 16'h0;
      sclkQ <= 1'b0;
    end else begin
      case (state_q)
        IDLE: begin
          sclkQ <= 1'b0;
          edgeCnt_q <= 5'h0;
          if (txLoad) begin
            // order chosen at load; shifter always sends bit 15
            shift_q <= lsbFirst ? bitRev(txBuf_q, wide)
                       : (wide ? txBuf_q : {txBuf_q[7:0], 8'h00});
            state_q <= SHIFT;
          end
        end
        SHIFT: begin
          if (stepEdge) begin
            sclkQ <= !sclkQ;
            edgeCnt_q <= edgeCnt_q + 5'h1;
            // change data on non-sampling edges; phase 1 holds bit 0 over edge 0
            if (!sampleEdge && edgeCnt_q != 5'h0) begin
              shift_q <= {shift_q[14:0], 1'b0};
            end
            if (edgeCnt_q == lastEdge) begin
              state_q <= master ? TRAIL : IDLE;
            end
          end
          if (!master && !slvSel) begin
            state_q <= IDLE;
          end
        end
        TRAIL: begin
          if (tick) begin
            state_q <= IDLE;
          end
        end
        default: state_q <= IDLE;
      endcase
    end
  end

  // Master samples a cycle late: its clock pin is a register behind the step
  assign takeBit = master ? sampleDly_q : (state_q == SHIFT && stepEdge && sampleEdge);
  assign finish = lastDly_q && enable && !abort;
  always_ff @(posedge ref_clk) begin
    if (!nrst || abort) begin
      sampleDly_q <= 1'b0;
      lastDly_q <= 1'b0;
      rxAsm_q <= 16'h0;
    end else begin
      sampleDly_q <= master && state_q == SHIFT && stepEdge && sampleEdge;
      lastDly_q <= state_q == SHIFT && stepEdge && (edgeCnt_q == lastEdge);
      if (takeBit) begin
        rxAsm_q <= {rxAsm_q[14:0], rxBit};
      end
    end
  end

  // ----------------------------------------------------------------
  // Buffers and flags
  // ----------------------------------------------------------------
  logic [15:0] rxFinal;
  always_comb begin
    rxFinal = takeBit ? {rxAsm_q[14:0], rxBit} : rxAsm_q;
    if (lsbFirst) begin
      rxFinal = bitRev(rxFinal, wide);
    end
    if (!wide) begin
      rxFinal = {8'h00, lsbFirst ? rxFinal[15:8] : rxFinal[7:0]};
    end
  end

  // select pulled low while master with fault input
  assign modfHit = enable && master && mode_fault_enable && !selOe && !selNIn && selPrev_q;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      txBuf_q <= 16'h0;
      rxBuf_q <= 16'h0;
      txFull_q <= 1'b0;
      done_q <= 1'b0;
      mode_fault_flag_q <= 1'b0;
    end else if (!enable) begin
      txFull_q <= 1'b0;
      done_q <= 1'b0;
      mode_fault_flag_q <= 1'b0;
    end else begin
      // Sets win over bus clears in the same cycle
      if (wrHit && address == REG_DATA_LOW) begin
        txBuf_q[7:0] <= writedata[7:0];
        txFull_q <= 1'b1;
      end else if (txLoad) begin
        txFull_q <= 1'b0;
      end
      if (wrHit && address == REG_DATA_HIGH) begin
        txBuf_q[15:8] <= writedata[7:0];
      end
      if (finish) begin
        rxBuf_q <= rxFinal;
        done_q <= 1'b1;
      end else if (rdHit && address == REG_DATA_LOW) begin
        done_q <= 1'b0;
      end
      if (modfHit) begin
        mode_fault_flag_q <= 1'b1;
      end else if (wrHit && address == REG_CTRL_ONE) begin
        mode_fault_flag_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pins and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sclkOut <= 1'b0;
      sclkOe <= 1'b0;
      mosiOut <= 1'b0;
      mosiOe <= 1'b0;
      misoOut <= 1'b0;
      misoOe <= 1'b0;
      selNOut <= 1'b1;
      selNOe <= 1'b0;
      irqReq <= 1'b0;
    end else begin
      sclkOut <= clock_polarity ^ (state_q == SHIFT && sclkQ);
      sclkOe <= enable && master;
      mosiOut <= shift_q[15];
      mosiOe <= enable && master;
      misoOut <= shift_q[15];
      misoOe <= enable && slvSel;
      // select output only with fault enable and select enable
      selNOut <= !(state_q != IDLE);
      selNOe <= enable && master && mode_fault_enable && selOe;
      irqReq <= (ctrlOne_q[C1_IRQ_EN] && (done_q || mode_fault_flag_q))
        || (ctrlOne_q[C1_TXE_IRQ_EN] && enable && !txFull_q);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_disable_idle;
    @(posedge ref_clk) disable iff (!nrst) !enable |=> state_q == IDLE && !done_q;
  endproperty
  a_disable_idle: assert property (p_disable_idle) else $error("not idle when disabled");
  property p_irq;
    @(posedge ref_clk) disable iff (!nrst)
      ctrlOne_q[C1_IRQ_EN] && done_q |=> irqReq;
  endproperty
  a_irq: assert property (p_irq) else $error("missing irq");
  property p_txe_irq;
    @(posedge ref_clk) disable iff (!nrst)
      !ctrlOne_q[C1_IRQ_EN] && !ctrlOne_q[C1_TXE_IRQ_EN] |=> !irqReq;
  endproperty
  a_txe_irq: assert property (p_txe_irq) else $error("irq without enable");
  property p_mode_abort;
    @(posedge ref_clk) disable iff (!nrst) $changed(master) |=> state_q == IDLE;
  endproperty
  a_mode_abort: assert property (p_mode_abort) else $error("mode change kept transfer");
  property p_idle_clk;
    @(posedge ref_clk) disable iff (!nrst) state_q == IDLE ##1 state_q == IDLE |-> sclkOut == $past(clock_polarity);
  endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("idle clock level wrong");
  property p_sel_oe;
    @(posedge ref_clk) disable iff (!nrst) selNOe |-> $past(master && mode_fault_enable && selOe);
  endproperty
  a_sel_oe: assert property (p_sel_oe) else $error("select driven wrongly");
  property p_fmt_abort;
    @(posedge ref_clk) disable iff (!nrst) master && $changed(clock_phase) |=> state_q == IDLE;
  endproperty
  a_fmt_abort: assert property (p_fmt_abort) else $error("format change kept transfer");
  property p_reserved;
    @(posedge ref_clk) disable iff (!nrst) (ctrlTwo_q & ~C2_MASK) == 8'h00 && (baud_q & ~BAUD_MASK) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");
  c_master_xfer: cover property (@(posedge ref_clk) master && finish);
  c_slave_xfer: cover property (@(posedge ref_clk) !master && finish);
  c_mode_fault_flag: cover property (@(posedge ref_clk) modfHit);
endmodule

// ==== bench/spi_peer.sv ====
/*
  Peer slave model that answers the port while the port is master.
  Assumes the bench gives it the same polarity, phase, order and width as the port.
*/
`timescale 1ns/1ps
module spi_peer (
  input wire logic sclk,
  input wire logic selN,
  input wire logic mosi,
  input wire logic clock_polarity,
  input wire logic clock_phase,
  input wire logic lsbFirst,
  input wire logic wide,
  input wire logic [15:0] txWord,
  output logic miso,
  output logic [15:0] rxWord
);
  int n;
  logic [15:0] tx;
  function automatic logic bitAt(int i);
    return lsbFirst ? tx[i] : tx[(wide ? 15 : 7) - i];
  endfunction
  initial miso = 1'b0;
  // framed by select, same polarity as the port
  always @(negedge selN) begin
    n = 0;
    rxWord = 16'h0000;
    tx = txWord;
    if (!clock_phase) miso = bitAt(0);
  end
  // Released line must not keep a stale bit
  always @(posedge selN) miso = ~miso;
  always @(sclk) begin
    if (!selN) begin
      if ((sclk != clock_polarity) ^ clock_phase) begin
        if (lsbFirst) rxWord[n] = mosi;
        else rxWord = {rxWord[14:0], mosi};
        n++;
      end else if (n < (wide ? 16 : 8)) miso = bitAt(n);
    end
  end
endmodule

// ==== bench/testbench.sv ====
/*
  Self-checking bench: registers over Avalon-MM, master frames against the peer,
  aborts, disable and bench-driven slave frames.
  Assumes waitrequest idles high and drops for one cycle per access.
*/
`timescale 1ns/1ps
module testbench;
  import spi_port_pkg::*;
  logic ref_clk, nrst, read, write, irqReq, waitrequest, masterRun;
  logic [2:0] address;
  logic [31:0] writedata, readdata, rd, seed;
  logic sclkOut, sclkOe, mosiOut, mosiOe, misoOut, misoOe, selNOut, selNOe;
  logic tbSclk, tbMosi, tbSel, peerMiso, clock_polarity, clock_phase, lsb, wide;
  logic [15:0] peerTx, peerRx, word;
  int nMismatch, nChecks, half;
  time lastEdge;
  wire logic sclkW = sclkOe ? sclkOut : tbSclk;
  wire logic mosiW = mosiOe ? mosiOut : tbMosi;
  wire logic misoW = misoOe ? misoOut : peerMiso;
  wire logic selW = selNOe ? selNOut : tbSel;
  localparam logic [7:0] ABORT_BIT [5] = '{8'h08, 8'h04, 8'h02, 8'h01, 8'h10};

  spi_port dut (.ref_clk(ref_clk), .nrst(nrst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .irqReq(irqReq), .sclkOut(sclkOut), .sclkOe(sclkOe), .sclkIn(sclkW),
    .mosiOut(mosiOut), .mosiOe(mosiOe), .mosiIn(mosiW), .misoOut(misoOut),
    .misoOe(misoOe), .misoIn(misoW), .selNOut(selNOut), .selNOe(selNOe), .selNIn(selW));
  spi_peer peer (.sclk(sclkW), .selN(selNOe ? selNOut : 1'b1), .mosi(mosiW), .clock_polarity(clock_polarity),
    .clock_phase(clock_phase), .lsbFirst(lsb), .wide(wide), .txWord(peerTx), .miso(peerMiso),
    .rxWord(peerRx));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] expData(logic [15:0] w);
    return wide ? w : {8'h00, w[7:0]};
  endfunction
  function automatic int pos(int i);
    return lsb ? i : (wide ? 15 : 7) - i;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    nChecks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic access(input logic wr, input logic [2:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    address <= a;
    writedata <= {24'h000000, d};
    read <= !wr;
    write <= wr;
    do begin
      @(posedge ref_clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 100);
    if (waitrequest !== 1'b0) nMismatch++;
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic pollDone();
    int k;
    k = 0;
    do begin
      access(1'b0, REG_STATUS, 8'h00);
      k++;
    end while (rd[S_DONE] !== 1'b1 && k < 300);
    if (rd[S_DONE] !== 1'b1) nMismatch++;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", nChecks, nMismatch);
    if (nMismatch == 0 && nChecks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  always @(sclkW) begin
    if (masterRun && lastEdge != 0) check(16'(($time - lastEdge) / 100), 16'(half));
    lastEdge = $time;
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic masterXfer(input logic irqOn);
    logic [31:0] x;
    x = rnd();
    {wide, lsb, clock_phase, clock_polarity} = x[3:0];
    half = (int'(x[4]) + 1) << x[5];
    peerTx = x[31:16];
    access(1'b1, REG_CTRL_TWO, {1'b0, wide, 6'h10});
    access(1'b1, REG_BAUD, {3'h0, x[4], 3'h0, x[5]});
    access(1'b1, REG_CTRL_ONE, {irqOn, 7'h52} | {4'h0, clock_polarity, clock_phase, 1'b0, lsb});
    access(1'b1, REG_DATA_HIGH, word[15:8]);
    lastEdge = 0;
    masterRun = 1'b1;
    access(1'b1, REG_DATA_LOW, word[7:0]);
    pollDone();
    masterRun = 1'b0;
    check(rd[7:0], 8'hA0);
    check(irqReq, irqOn);
    check(sclkW, clock_polarity);
    check(selNOe, 1'b1);
    check(peerRx, expData(word));
    access(1'b0, REG_DATA_HIGH, 8'h00);
    if (wide) check(rd[7:0], peerTx[15:8]);
    access(1'b0, REG_DATA_LOW, 8'h00);
    check(rd[7:0], peerTx[7:0]);
    repeat (2) @(posedge ref_clk);
    check(irqReq, 1'b0);
  endtask

  task automatic slaveXfer();
    logic [31:0] x;
    logic [15:0] sent, back;
    int nb;
    x = rnd();
    {wide, lsb, clock_phase, clock_polarity} = x[3:0];
    sent = x[31:16];
    word = rnd();
    back = 16'h0000;
    nb = wide ? 16 : 8;
    tbSclk <= clock_polarity;
    access(1'b1, REG_CTRL_TWO, {1'b0, wide, 6'h00});
    access(1'b1, REG_CTRL_ONE, 8'h40 | {4'h0, clock_polarity, clock_phase, 1'b0, lsb});
    access(1'b1, REG_DATA_HIGH, word[15:8]);
    access(1'b1, REG_DATA_LOW, word[7:0]);
    tbSel <= 1'b0;
    tbMosi <= sent[pos(0)];
    for (int i = 0; i < nb; i++) begin
      repeat (8) @(posedge ref_clk);
      tbSclk <= ~clock_polarity;
      if (clock_phase) tbMosi <= sent[pos(i)];
      else back[pos(i)] = misoW;
      repeat (8) @(posedge ref_clk);
      tbSclk <= clock_polarity;
      if (clock_phase) back[pos(i)] = misoW;
      else if (i < nb - 1) tbMosi <= sent[pos(i + 1)];
    end
    repeat (8) @(posedge ref_clk);
    tbSel <= 1'b1;
    tbMosi <= ~tbMosi;
    pollDone();
    check(back, expData(word));
    access(1'b0, REG_DATA_HIGH, 8'h00);
    if (wide) check(rd[7:0], sent[15:8]);
    access(1'b0, REG_DATA_LOW, 8'h00);
    check(rd[7:0], sent[7:0]);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    #6000000;
    nMismatch++;
    final_report();
  end
  initial begin
    {nrst, read, write, masterRun, tbSclk, tbMosi, clock_polarity, clock_phase, lsb, wide} = '0;
    tbSel = 1'b1;
    address = 3'h0;
    writedata = 32'h00000000;
    peerTx = 16'h0000;
    word = 16'h0000;
    seed = 32'h00000019;
    nMismatch = 0;
    nChecks = 0;
    lastEdge = 0;
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    access(1'b0, REG_CTRL_ONE, 8'h00);
    check(rd[7:0], CTRL_ONE_RST);
    for (int a = 0; a < 8; a++) begin
      if (a > 2 && a < 6) continue;
      access(1'b1, 3'(a), 8'hFF);
      access(1'b0, 3'(a), 8'h00);
      check(rd[7:0], a == 1 ? C2_MASK : a == 2 ? BAUD_MASK : a == 0 ? 8'hFF : 8'h00);
    end
    access(1'b1, REG_CTRL_ONE, 8'h60);
    repeat (2) @(posedge ref_clk);
    check(irqReq, 1'b1);
    access(1'b1, REG_CTRL_ONE, 8'h40);
    repeat (2) @(posedge ref_clk);
    check(irqReq, 1'b0);
    for (int i = 0; i < 8; i++) begin
      word = i == 0 ? 16'h8001 : 16'(rnd());
      masterXfer(i[0]);
    end
    foreach (ABORT_BIT[i]) begin
      // Slow clock so the frame is still running when it is cut
      access(1'b1, REG_BAUD, 8'h22);
      access(1'b1, REG_CTRL_ONE, 8'h52);
      access(1'b1, REG_DATA_LOW, 8'hC3);
      repeat (20) @(posedge ref_clk);
      access(1'b1, REG_CTRL_ONE, 8'h52 ^ ABORT_BIT[i]);
      repeat (100) @(posedge ref_clk);
      access(1'b0, REG_STATUS, 8'h00);
      check(rd[S_DONE], 1'b0);
    end
    access(1'b1, REG_CTRL_ONE, 8'h52);
    access(1'b1, REG_DATA_LOW, 8'h5A);
    pollDone();
    access(1'b1, REG_CTRL_ONE, 8'h00);
    access(1'b0, REG_STATUS, 8'h00);
    check(rd[7:0], 8'h20); // empty buffer still reads as tx empty
    check({sclkOe, mosiOe}, 2'b00);
    repeat (3) slaveXfer();
    final_report();
  end
endmodule
